// file: logic/cbceu_decode.sv
// Instruction field decoder for the conditional branch unit.
`timescale 1ns/100ps
module cbceu_decode (
	input  wire logic [31:0]          instr,
	output cbceu_pkg::cbceu_dec_t     dec
);
	import cbceu_pkg::*;

	wire logic       op_second_coprocessor    = (instr[OP_HI:OP_LO] == OPC_SECOND_COPROCESSOR);
	wire logic       sub_bc     = (instr[SRC_A_HI:SRC_A_LO] == SUBOP_BC);
	wire logic       nd_flag    = instr[NULLIFY_BIT];
	wire logic       tf_flag    = instr[TRUE_BIT];
	wire logic       cop_branch = op_second_coprocessor & sub_bc & tf_flag;

	assign dec.cop_true          = cop_branch & ~nd_flag;
	assign dec.cop_true_likely   = cop_branch & nd_flag;
	assign dec.regs_equal        = (instr[OP_HI:OP_LO] == OPC_EQ);
	assign dec.regs_equal_likely = (instr[OP_HI:OP_LO] == OPC_EQ_LIKE);
	assign dec.cond_sel          = instr[SEL_HI:SEL_LO];
	assign dec.src_a             = instr[SRC_A_HI:SRC_A_LO];
	assign dec.src_b             = instr[SRC_B_HI:SRC_B_LO];
	assign dec.offset            = instr[OFF_HI:OFF_LO];
endmodule

// file: logic/cbceu_pkg.sv
// Package with encodings, field positions and carrier types of the conditional branch unit.
package cbceu_pkg;
	localparam int unsigned XLEN         = 32;
	localparam int unsigned OP_HI        = 31;
	localparam int unsigned OP_LO        = 26;
	localparam int unsigned SRC_A_HI     = 25;
	localparam int unsigned SRC_A_LO     = 21;
	localparam int unsigned SRC_B_HI     = 20;
	localparam int unsigned SRC_B_LO     = 16;
	localparam int unsigned SEL_HI       = 20;
	localparam int unsigned SEL_LO       = 18;
	localparam int unsigned NULLIFY_BIT  = 17;
	localparam int unsigned TRUE_BIT     = 16;
	localparam int unsigned OFF_HI       = 15;
	localparam int unsigned OFF_LO       = 0;
	localparam int unsigned OFF_W        = 16;
	localparam int unsigned OFF_SHIFT    = 2;
	localparam int unsigned COND_BITS    = 8;
	localparam int unsigned SEL_W        = 3;
	localparam int unsigned REG_SEL_W    = 5;
	localparam logic [5:0]  OPC_SECOND_COPROCESSOR     = 6'h12;
	localparam logic [5:0]  OPC_EQ       = 6'h04;
	localparam logic [5:0]  OPC_EQ_LIKE  = 6'h14;
	localparam logic [4:0]  SUBOP_BC     = 5'h08;
	localparam logic [XLEN-1:0] SLOT_STEP = 32'h0000_0004;
	localparam logic [XLEN-1:0] PC_RESET  = 32'h0000_0000;

	typedef enum logic [1:0] {
		CBCEU_IDLE     = 2'b00,
		CBCEU_SLOT     = 2'b01,
		CBCEU_REDIRECT = 2'b11
	} cbceu_state_t;

	// Decoded view of one instruction word.
	typedef struct packed {
		logic                 cop_true;
		logic                 cop_true_likely;
		logic                 regs_equal;
		logic                 regs_equal_likely;
		logic [SEL_W-1:0]     cond_sel;
		logic [REG_SEL_W-1:0] src_a;
		logic [REG_SEL_W-1:0] src_b;
		logic [OFF_W-1:0]     offset;
	} cbceu_dec_t;

	// Branch outcome carried from the branch step to the delay-slot step.
	typedef struct packed {
		logic            taken;
		logic            likely;
		logic [XLEN-1:0] target;
	} cbceu_pend_t;
endpackage

// file: logic/cbceu_unit.sv
// Decode and execute of the coprocessor-true and register-equality branches.
`timescale 1ns/100ps
module cbceu_unit #(
	parameter int unsigned W = cbceu_pkg::XLEN
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        instr_valid,
	input  wire logic [31:0]                 instr,
	input  wire logic [W-1:0]                instr_pc,
	input  wire logic [W-1:0]                src_a_value,
	input  wire logic [W-1:0]                src_b_value,
	input  wire logic [cbceu_pkg::COND_BITS-1:0] coprocessor_condition_bit,
	input  wire logic                        second_coprocessor_present,
	input  wire logic                        second_coprocessor_usable,
	input  wire logic                        slot_reg_wr_req,
	input  wire logic                        slot_mem_req,
	input  wire logic                        slot_exc_req,
	output logic                             slot_reg_wr_en,
	output logic                             slot_mem_en,
	output logic                             slot_exc_en,
	output logic                             cancel_slot_instruction,
	output logic                             pc_redirect,
	output logic [W-1:0]                     pc_target,
	output logic                             exc_cop_unusable,
	output logic                             exc_reserved_instr,
	output logic                             branch_busy
);
	import cbceu_pkg::*;

	cbceu_dec_t   dec;
	cbceu_state_t state_q;
	cbceu_state_t state_d;
	cbceu_pend_t  pend_q;
	cbceu_pend_t  pend_d;
	logic [W-1:0] target_q;
	logic [W-1:0] target_d;
	logic         exc_cu_q;
	logic         exc_ri_q;

	function automatic logic [W-1:0] branch_target(input logic [W-1:0] pc,
			input logic [OFF_W-1:0] off);
		logic [W-1:0] ext;
		ext = {{(W-OFF_W-OFF_SHIFT){off[OFF_W-1]}}, off, {OFF_SHIFT{1'b0}}};
		branch_target = pc + SLOT_STEP[W-1:0] + ext;
	endfunction

	cbceu_decode u_decode (
		.instr (instr),
		.dec   (dec)
	);

	// A branch seen while a slot is pending is the slot itself and is not decoded as a branch.
	wire logic accept_branch = instr_valid & (state_q == CBCEU_IDLE);
	wire logic is_cop        = dec.cop_true | dec.cop_true_likely;
	wire logic is_eq         = dec.regs_equal | dec.regs_equal_likely;
	wire logic is_likely     = dec.cop_true_likely | dec.regs_equal_likely;
	wire logic cop_cond      = coprocessor_condition_bit[dec.cond_sel];
	// Register zero compared with itself matches by value, so it is always taken.
	wire logic regs_match    = (src_a_value == src_b_value);
	wire logic cond_now      = is_cop ? cop_cond : regs_match;
	wire logic ri_now        = accept_branch & is_cop & ~second_coprocessor_present;
	wire logic cu_now        = accept_branch & is_cop & second_coprocessor_present
	                           & ~second_coprocessor_usable;
	wire logic start_branch  = accept_branch & (is_eq | is_cop) & ~ri_now & ~cu_now;
	wire logic slot_seen     = instr_valid & (state_q == CBCEU_SLOT);
	wire logic slot_cancel   = slot_seen & pend_q.likely & ~pend_q.taken;

	assign cancel_slot_instruction = slot_cancel;
	assign slot_reg_wr_en = slot_reg_wr_req & ~slot_cancel;
	assign slot_mem_en    = slot_mem_req & ~slot_cancel;
	assign slot_exc_en    = slot_exc_req & ~slot_cancel;
	assign pc_redirect    = (state_q == CBCEU_REDIRECT);
	assign pc_target      = target_q;
	assign exc_cop_unusable   = exc_cu_q;
	assign exc_reserved_instr = exc_ri_q;
	assign branch_busy    = (state_q != CBCEU_IDLE);

	always_comb begin
		state_d  = state_q;
		pend_d   = pend_q;
		target_d = target_q;
		case (state_q)
			CBCEU_IDLE: begin
				if (start_branch) begin
					pend_d.taken  = cond_now;
					pend_d.likely = is_likely;
					pend_d.target = branch_target(instr_pc, dec.offset);
					state_d       = CBCEU_SLOT;
				end
			end
			CBCEU_SLOT: begin
				// The slot runs first; the redirect follows only once it has been issued.
				if (slot_seen) begin
					if (pend_q.taken) begin
						target_d = pend_q.target;
						state_d  = CBCEU_REDIRECT;
					end else begin
						state_d  = CBCEU_IDLE;
					end
				end
			end
			CBCEU_REDIRECT: begin
				state_d = CBCEU_IDLE;
			end
			default: begin
				state_d = CBCEU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q  <= CBCEU_IDLE;
			pend_q   <= '0;
			target_q <= PC_RESET[W-1:0];
			exc_cu_q <= 1'b0;
			exc_ri_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			pend_q   <= pend_d;
			target_q <= target_d;
			exc_cu_q <= cu_now;
			exc_ri_q <= ri_now;
		end
	end

	// Helper copy of the last started branch (start_branch) for the checks below.
	logic         chk_cop_q;
	logic         chk_eq_q;
	logic         chk_likely_q;
	logic         chk_cond_q;
	logic [W-1:0] chk_tgt_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chk_cop_q    <= 1'b0;
			chk_eq_q     <= 1'b0;
			chk_likely_q <= 1'b0;
			chk_cond_q   <= 1'b0;
			chk_tgt_q    <= '0;
		end else if (start_branch) begin
			chk_cop_q    <= is_cop;
			chk_eq_q     <= is_eq;
			chk_likely_q <= is_likely;
			chk_cond_q   <= is_cop ? cop_cond : regs_match;
			chk_tgt_q    <= instr_pc + SLOT_STEP[W-1:0]
			                + W'($signed({dec.offset, 2'b00}));
		end
	end

	AST_COP_TRUE_DECODE: assert property (@(posedge clk_sys) disable iff (rst)
		(instr[31:26] == 6'h12 && instr[25:21] == 5'h08 && !instr[17] && instr[16])
		|-> dec.cop_true && !dec.cop_true_likely)
		else $error("coprocessor-true branch not decoded");

	AST_COP_LIKELY_DECODE: assert property (@(posedge clk_sys) disable iff (rst)
		dec.cop_true_likely |-> (instr[31:26] == 6'h12 && instr[17] && instr[16]))
		else $error("likely coprocessor branch decoded from wrong bits");

	AST_TARGET: assert property (@(posedge clk_sys) disable iff (rst)
		start_branch && cond_now ##1 slot_seen |=> pc_redirect && pc_target == chk_tgt_q)
		else $error("branch target wrong");

	AST_COND_SELECT: assert property (@(posedge clk_sys) disable iff (rst)
		start_branch && is_cop |=> pend_q.taken == $past(coprocessor_condition_bit[dec.cond_sel]))
		else $error("wrong condition bit tested");

	AST_REDIRECT_AFTER_SLOT: assert property (@(posedge clk_sys) disable iff (rst)
		pc_redirect |-> $past(slot_seen) && $past(pend_q.taken))
		else $error("redirect without a completed delay slot");

	AST_NO_EARLY_REDIRECT: assert property (@(posedge clk_sys) disable iff (rst)
		start_branch |=> !pc_redirect)
		else $error("redirect in branch step");

	AST_LIKELY_CANCEL: assert property (@(posedge clk_sys) disable iff (rst)
		start_branch && is_likely && !cond_now ##1 slot_seen |-> cancel_slot_instruction
		##1 !pc_redirect)
		else $error("untaken likely branch did not cancel its slot");

	AST_EQ_SLOT_RUNS: assert property (@(posedge clk_sys) disable iff (rst)
		start_branch && dec.regs_equal ##1 slot_seen |-> !cancel_slot_instruction)
		else $error("equality branch cancelled its slot");

	AST_EQ_LIKELY_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
		start_branch && dec.regs_equal_likely && regs_match ##1 slot_seen |=> pc_redirect)
		else $error("equal likely branch not taken");

	AST_EQ_NO_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
		accept_branch && is_eq && !is_cop |=> !exc_cop_unusable && !exc_reserved_instr)
		else $error("equality branch raised a fault");

	AST_COP_UNUSABLE: assert property (@(posedge clk_sys) disable iff (rst)
		accept_branch && is_cop && second_coprocessor_present && !second_coprocessor_usable
		|=> exc_cop_unusable && !branch_busy)
		else $error("unusable coprocessor not reported");

	AST_ZERO_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
		start_branch && dec.regs_equal && dec.src_a == 5'h00 && dec.src_b == 5'h00
		&& src_a_value == src_b_value |=> pend_q.taken)
		else $error("branch on zero equal zero not taken");

	AST_CANCEL_GATES: assert property (@(posedge clk_sys) disable iff (rst)
		cancel_slot_instruction |-> !slot_reg_wr_en && !slot_mem_en && !slot_exc_en)
		else $error("cancelled slot still has effect");

	COV_COP_TAKEN: cover property (@(posedge clk_sys) disable iff (rst)
		start_branch && dec.cop_true && cop_cond ##1 slot_seen ##1 pc_redirect);
	COV_LIKELY_CANCEL: cover property (@(posedge clk_sys) disable iff (rst)
		slot_cancel && chk_likely_q && chk_cop_q);
	COV_EQ_TAKEN: cover property (@(posedge clk_sys) disable iff (rst)
		start_branch && dec.regs_equal && regs_match ##1 slot_seen ##1 pc_redirect);
	COV_EQ_LIKELY_NOT: cover property (@(posedge clk_sys) disable iff (rst)
		slot_cancel && chk_eq_q && !chk_cond_q);
endmodule

// file: verification/cbceu_cop_model.sv
// Behavioural model of the second coprocessor that supplies the branch condition bits.
`timescale 1ns/100ps
module cbceu_cop_model (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic [7:0] load_bits,
	input  wire logic       present_in,
	input  wire logic       enabled_in,
	output logic [7:0]      coprocessor_condition_bit,
	output logic            second_coprocessor_present,
	output logic            second_coprocessor_usable
);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			coprocessor_condition_bit <= 8'h00;
		end else if (load) begin
			coprocessor_condition_bit <= load_bits;
		end
	end
	assign second_coprocessor_present = present_in;
	assign second_coprocessor_usable  = enabled_in;
endmodule

// file: verification/tb_cond_branch_cop_equal_unit.sv
// Self-checking testbench of the conditional branch unit.
`timescale 1ns/100ps
module tb_cond_branch_cop_equal_unit;
	import cbceu_pkg::*;
	logic        clk_sys, rst, instr_valid, ld, pres, ena, rq;
	logic        rwe, me, ee, cancel, redir, exu, exr, busy;
	logic [31:0] instr, pc, va, vb, seed, tgt, a;
	logic [7:0]  bits, cc;
	logic [15:0] off;
	logic [2:0]  sel;
	logic [33:0] expq[$];
	int          n_fail, checks, cyc;
	logic        pres_o, use_o;
	cbceu_unit #(.W(32)) dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
		.instr(instr), .instr_pc(pc), .src_a_value(va), .src_b_value(vb),
		.coprocessor_condition_bit(cc), .second_coprocessor_present(pres_o),
		.second_coprocessor_usable(use_o), .slot_reg_wr_req(rq), .slot_mem_req(rq),
		.slot_exc_req(rq), .slot_reg_wr_en(rwe), .slot_mem_en(me), .slot_exc_en(ee),
		.cancel_slot_instruction(cancel), .pc_redirect(redir), .pc_target(tgt),
		.exc_cop_unusable(exu), .exc_reserved_instr(exr), .branch_busy(busy));
	cbceu_cop_model cop (.clk_sys(clk_sys), .rst(rst), .load(ld), .load_bits(bits),
		.present_in(pres), .enabled_in(ena), .coprocessor_condition_bit(cc),
		.second_coprocessor_present(pres_o), .second_coprocessor_usable(use_o));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp_rec(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_rec({33'h0, got}, {33'h0, exp});
	endtask
	task automatic finish_test();
		if (expq.size() != 0) n_fail++;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Issues a branch and, when flt is zero, its slot; flt is {unusable, reserved}, nb marks a word that is no branch.
	task automatic branch(input logic [31:0] iw, input logic [31:0] x, input logic [31:0] y,
		input logic tk, input logic lk, input logic [1:0] flt, input logic nb);
		logic [31:0] p;
		logic        act;
		seed = lfsr(seed);
		p = {seed[31:2], 2'b00};
		act = (flt == 2'b00) && !nb;
		@(posedge clk_sys);
		#2;
		instr_valid = 1'b1;
		instr = iw;
		pc = p;
		va = x;
		vb = y;
		if (flt != 2'b00) expq.push_back({2'b01, 30'h0, flt});
		else if (tk && !nb) expq.push_back({2'b10, p + 32'h4 + {{14{iw[15]}}, iw[15:0], 2'b00}});
		@(posedge clk_sys);
		#2;
		instr = 32'h0000_0000; // The slot holds a plain no-op, never a branch.
		rq = 1'b1;
		instr_valid = (flt == 2'b00);
		#1;
		cmp_bit(busy, act);
		cmp_bit(cancel, act & lk & ~tk);
		if (flt == 2'b00) cmp_bit(rwe & me & ee, ~(act & lk & ~tk));
		@(posedge clk_sys);
		#2;
		instr_valid = 1'b0;
		rq = 1'b0;
		cmp_bit(redir, act & tk);
		repeat (3) @(posedge clk_sys);
		#2;
		$display("test %h done", iw);
	endtask
	always @(negedge clk_sys) begin
		if (!rst && (redir === 1'b1 || exu === 1'b1 || exr === 1'b1)) begin
			if (expq.size() == 0) cmp_rec({2'b11, tgt}, 34'h0);
			else cmp_rec(redir === 1'b1 ? {2'b10, tgt} : {2'b01, 30'h0, exu, exr},
				expq.pop_front());
		end
	end
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		{rst, instr_valid, ld, rq, instr, pc, va, vb, bits} = {4'hf, 136'h0};
		{pres, ena, seed} = {2'b11, 32'hbb96cafc};
		repeat (10) @(posedge clk_sys);
		#2;
		rst = 1'b0;
		for (int i = 0; i < 64; i++) begin
			seed = lfsr(seed);
			off = seed[31:16];
			sel = seed[4:2];
			ld = 1'b1;
			bits = seed[15:8];
			@(posedge clk_sys);
			#2;
			ld = 1'b0;
			a = lfsr(seed);
			case (seed[1:0])
				2'd0: branch({OPC_SECOND_COPROCESSOR, SUBOP_BC, sel, 2'b01, off}, a, ~a, bits[sel], 1'b0, 2'b00, 1'b0);
				2'd1: branch({OPC_SECOND_COPROCESSOR, SUBOP_BC, sel, 2'b11, off}, a, a, bits[sel], 1'b1, 2'b00, 1'b0);
				2'd2: branch({OPC_EQ, a[9:0], off}, a, a ^ {31'h0, seed[5]}, ~seed[5], 1'b0, 2'b00, 1'b0);
				default: branch({OPC_EQ_LIKE, a[9:0], off}, a, a ^ {31'h0, seed[5]}, ~seed[5], 1'b1, 2'b00, 1'b0);
			endcase
		end
		branch({OPC_EQ, 10'h000, 16'h8000}, 32'h0, 32'h0, 1'b1, 1'b0, 2'b00, 1'b0);
		branch({OPC_SECOND_COPROCESSOR, SUBOP_BC, 3'h0, 2'b00, 16'h0010}, a, a, 1'b0, 1'b0, 2'b00, 1'b1);
		ena = 1'b0;
		branch({OPC_SECOND_COPROCESSOR, SUBOP_BC, 3'h7, 2'b01, 16'h7fff}, a, a, 1'b0, 1'b0, 2'b10, 1'b0);
		branch({OPC_EQ_LIKE, 10'h3ff, 16'h7fff}, a, a, 1'b1, 1'b1, 2'b00, 1'b0);
		pres = 1'b0;
		branch({OPC_SECOND_COPROCESSOR, SUBOP_BC, 3'h2, 2'b11, 16'h0001}, a, a, 1'b0, 1'b1, 2'b01, 1'b0);
		finish_test();
	end
endmodule
